//--- verilog/tcsrc_top.sv
// tcsrc_top: transmit input clock selection, rate control and output clock shaping with an AXI4-Lite register slave
//
// Overview of operation
// [RULE1] low select: reference clock loads input register
// [RULE2] host never pairs host clock with high rate
// [RULE3] tx clock output: reference rate, doubled when high
// [RULE4] high rate: bit clock twenty times reference
// [RULE5] low rate: bit clock ten times reference
// [RULE6] rx select low, rate high: half-rate rx clocks
// [RULE7] rx select low, rate low: full-rate rx clocks
// [RULE8] host clock matches tx clock output frequency
// [RULE9] track host clock phase until phase reset high
// [RULE10] two three-level inputs decode nine modes
// [RULE11] tx clock output true and complement, character-synchronous
// [RULE12] tx clock output phase unrelated to reference
// [RULE13] three-level controls resolve to low, mid, high
//
// Our own choices: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module tcsrc_top
	import tcsrc_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// clock and data pins from the host side
	input wire logic referenceClockIn,
	input wire logic txHostInputClock,
	input wire logic [7:0] txDataIn,
	input wire logic [1:0] txCharacterType,
	// axi4-lite write address and data
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	// axi4-lite write response
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	// axi4-lite read
	input wire logic arvalid,
	output logic arready,
	input wire logic [31:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	// generated clocks
	output logic txClockOutput,
	output logic txClockOutputN,
	output logic rxClockOutput,
	output logic rxClockCopyOutput,
	// input register contents
	output logic [7:0] txHeldData,
	output logic [1:0] txHeldCharType,
	output logic txHeldStrobe
);

	// synchroniser chains: first stage feeds only the second
	logic [SYNC_WIDTH-1:0] syncA_r;
	logic [SYNC_WIDTH-1:0] syncB_r;
	logic [SYNC_WIDTH-1:0] syncC_r;
	logic [SYNC_WIDTH-1:0] pinStable_r;
	logic [SYNC_WIDTH-1:0] pinStable_nxt;
	logic [SYNC_WIDTH-1:0] pinRaw;
	assign pinRaw = {txCharacterType, txDataIn, txHostInputClock, referenceClockIn};

	genvar gi;
	generate
		for (gi = 0; gi < SYNC_WIDTH; gi++) begin : gSync
			// a change counts only once stages two and three agree
			assign pinStable_nxt[gi] = (syncB_r[gi] == syncC_r[gi]) ? syncC_r[gi] : pinStable_r[gi];
			always_ff @(posedge sys_clk) begin
				if (reset) begin
					syncA_r[gi] <= 1'b0;
					syncB_r[gi] <= 1'b0;
					syncC_r[gi] <= 1'b0;
					pinStable_r[gi] <= 1'b0;
				end else begin
					syncA_r[gi] <= pinRaw[gi];
					syncB_r[gi] <= syncA_r[gi];
					syncC_r[gi] <= syncB_r[gi];
					pinStable_r[gi] <= pinStable_nxt[gi];
				end
			end
		end
	endgenerate

	// edge detection on the filtered clock pins
	wire logic refLevel = pinStable_r[0];
	wire logic hostLevel = pinStable_r[1];
	wire logic refEdge = pinStable_nxt[0] ^ pinStable_r[0];
	wire logic hostRise = pinStable_nxt[1] & ~pinStable_r[1];
	wire logic hostEdge = pinStable_nxt[1] ^ pinStable_r[1];
	wire logic refRise = pinStable_nxt[0] & ~pinStable_r[0];

	// control register and its decoded fields
	logic [31:0] ctrl_r;
	tcsrc_ctrl_t ctrlF;
	assign ctrlF = tcsrc_ctrl_t'(ctrl_r[8:0]);

	// three-level resolution: codes 2 and 3 both mean high
	tcsrc_level_t txSelLvl;
	tcsrc_level_t mode0Lvl;
	tcsrc_level_t mode1Lvl;
	assign txSelLvl = ctrlF.txInputSelect[1] ? LVL_HIGH :
		(ctrlF.txInputSelect == LEVEL_MID_CODE) ? LVL_MID : LVL_LOW; // [RULE13]
	assign mode0Lvl = ctrlF.txMode0[1] ? LVL_HIGH : (ctrlF.txMode0 == LEVEL_MID_CODE) ? LVL_MID : LVL_LOW; // [RULE13]
	assign mode1Lvl = ctrlF.txMode1[1] ? LVL_HIGH : (ctrlF.txMode1 == LEVEL_MID_CODE) ? LVL_MID : LVL_LOW; // [RULE13]

	// nine transmit modes from the two three-level inputs
	logic [3:0] modeProduct;
	tcsrc_mode_t tx_operating_mode_select;
	assign modeProduct = 4'(4'(mode1Lvl) * MODES_PER_LEVEL);
	assign tx_operating_mode_select = tcsrc_mode_t'(4'(modeProduct + 4'(mode0Lvl))); // [RULE10]

	// host clock only when the select is mid or high
	wire logic useHostClock = (txSelLvl != LVL_LOW); // [RULE1]
	// the configuring party keeps this pairing out; it is only reported
	wire logic invalidCombo = useHostClock & ctrlF.rateSelect; // [RULE2]
	wire logic loadEdge = useHostClock ? hostRise : refRise; // [RULE1]

	// bit-rate multiplier of the transmit pll
	wire logic [4:0] pllMultiplier = ctrlF.rateSelect ? PLL_MULT_HALF : PLL_MULT_FULL; // [RULE4] [RULE5]

	// reference half-period measurement drives the output clock timing
	logic [15:0] sinceRef_r;
	logic [15:0] refHalf_r;
	logic [15:0] sinceHost_r;
	logic [15:0] hostHalf_r;
	wire logic [15:0] quarterPoint = 16'((refHalf_r >> 1) - CNT_ONE);
	wire logic midToggle = ctrlF.rateSelect & (refHalf_r > CNT_ONE) & (sinceRef_r == quarterPoint);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			sinceRef_r <= 16'h0000;
			refHalf_r <= 16'h0000;
			sinceHost_r <= 16'h0000;
			hostHalf_r <= 16'h0000;
		end else begin
			sinceRef_r <= refEdge ? 16'h0000 : 16'(sinceRef_r + CNT_ONE);
			if (refEdge) begin
				refHalf_r <= 16'(sinceRef_r + CNT_ONE);
			end
			sinceHost_r <= hostEdge ? 16'h0000 : 16'(sinceHost_r + CNT_ONE);
			if (hostEdge) begin
				hostHalf_r <= 16'(sinceHost_r + CNT_ONE);
			end
		end
	end

	// transmit clock output: toggles each reference half, and mid-half too at the high rate
	logic txClock_r;
	logic txClockN_r;
	wire logic txClockToggle = refEdge | midToggle; // [RULE3]
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			txClock_r <= 1'b0;
			txClockN_r <= 1'b1;
		end else if (txClockToggle) begin
			txClock_r <= ~txClock_r; // [RULE11]
			txClockN_r <= txClock_r; // [RULE11]
		end
	end

	// the output is re-timed through the pin filter, so its phase against the reference pin is not fixed [RULE12]
	wire logic [15:0] txHalf = ctrlF.rateSelect ? 16'(refHalf_r >> 1) : refHalf_r;
	wire logic [15:0] halfDiff = (hostHalf_r > txHalf) ? 16'(hostHalf_r - txHalf) : 16'(txHalf - hostHalf_r);
	wire logic freqMismatch = useHostClock & (halfDiff > MATCH_SLACK); // [RULE8]

	// host clock phase against the reference: tracked while phase reset is low, frozen when high
	logic [15:0] phaseOffset_r;
	logic freqMismatch_r;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			phaseOffset_r <= 16'h0000;
			freqMismatch_r <= 1'b0;
		end else begin
			if (hostRise & ~ctrlF.txPhaseReset) begin
				phaseOffset_r <= sinceRef_r; // [RULE9]
			end
			freqMismatch_r <= freqMismatch;
		end
	end

	// receive clocks follow the reference when selected low, otherwise the transmit clock
	logic rxClock_r;
	logic rxClockCopy_r;
	wire logic rxLevel = ctrlF.rxSelect ? txClock_r : refLevel; // [RULE6] [RULE7]
	wire logic rxHalfRate = ~ctrlF.rxSelect & ctrlF.rateSelect; // [RULE6] [RULE7]
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			rxClock_r <= 1'b0;
			rxClockCopy_r <= 1'b0;
		end else begin
			rxClock_r <= rxLevel;
			rxClockCopy_r <= rxLevel;
		end
	end

	// transmit input register, loaded on the selected clock's rising edge
	logic [DATA_WIDTH-1:0] heldData_r;
	logic [CT_WIDTH-1:0] heldCt_r;
	logic heldStrobe_r;
	logic [15:0] loadCount_r;
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			heldData_r <= 8'h00;
			heldCt_r <= 2'h0;
			heldStrobe_r <= 1'b0;
			loadCount_r <= 16'h0000;
		end else begin
			heldStrobe_r <= loadEdge;
			if (loadEdge) begin
				heldData_r <= pinStable_r[9:2]; // [RULE1]
				heldCt_r <= pinStable_r[11:10]; // [RULE1]
				loadCount_r <= 16'(loadCount_r + CNT_ONE);
			end
		end
	end

	// status word
	tcsrc_status_t statusW;
	always_comb begin
		statusW = '0;
		statusW.modeIndex = tx_operating_mode_select;
		statusW.invalidCombo = invalidCombo;
		statusW.pllMultiplier = pllMultiplier;
		statusW.rxHalfRate = rxHalfRate;
		statusW.hostClockInUse = useHostClock;
		statusW.phaseHeld = ctrlF.txPhaseReset;
		statusW.hostFreqMismatch = freqMismatch_r;
	end

	// write channel: address and data taken in either order, answer once both are held
	logic awready_r;
	logic wready_r;
	logic bvalid_r;
	logic [1:0] bresp_r;
	logic awHeld_r;
	logic wHeld_r;
	logic [31:0] awAddrHeld_r;
	logic [31:0] wDataHeld_r;
	logic [3:0] wStrbHeld_r;
	wire logic awTake = awvalid & awready_r;
	wire logic wTake = wvalid & wready_r;
	wire logic doWrite = awHeld_r & wHeld_r & ~bvalid_r;
	wire logic awHeld_nxt = doWrite ? 1'b0 : (awHeld_r | awTake);
	wire logic wHeld_nxt = doWrite ? 1'b0 : (wHeld_r | wTake);
	wire logic bvalid_nxt = doWrite | (bvalid_r & ~bready);
	wire logic [31:0] wrWord = awAddrHeld_r & ADDR_WORD_MASK;
	wire logic wrCtrl = (wrWord == CTRL_ADDR);
	wire logic wrKnown = wrCtrl | (wrWord == STATUS_ADDR) | (wrWord == PHASE_ADDR) | (wrWord == CAPTURE_ADDR);
	logic [31:0] ctrlMerged;
	generate
		for (gi = 0; gi < 4; gi++) begin : gLane
			assign ctrlMerged[gi*8 +: 8] = wStrbHeld_r[gi] ? wDataHeld_r[gi*8 +: 8] : ctrl_r[gi*8 +: 8];
		end
	endgenerate

	// write-side flops; read-only registers ignore writes but answer okay
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			awready_r <= 1'b0;
			wready_r <= 1'b0;
			bvalid_r <= 1'b0;
			bresp_r <= RESP_OKAY;
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddrHeld_r <= 32'h0000_0000;
			wDataHeld_r <= 32'h0000_0000;
			wStrbHeld_r <= 4'h0;
			ctrl_r <= CTRL_RESET;
		end else begin
			awHeld_r <= awHeld_nxt;
			wHeld_r <= wHeld_nxt;
			bvalid_r <= bvalid_nxt;
			awready_r <= ~awHeld_nxt & ~bvalid_nxt;
			wready_r <= ~wHeld_nxt & ~bvalid_nxt;
			if (awTake) begin
				awAddrHeld_r <= awaddr;
			end
			if (wTake) begin
				wDataHeld_r <= wdata;
				wStrbHeld_r <= wstrb;
			end
			if (doWrite) begin
				bresp_r <= wrKnown ? RESP_OKAY : RESP_SLVERR;
				if (wrCtrl) begin
					ctrl_r <= ctrlMerged & CTRL_MASK;
				end
			end
		end
	end

	// read decode
	wire logic [31:0] rdWord = araddr & ADDR_WORD_MASK;
	logic [31:0] rdMux;
	logic rdKnown;
	always_comb begin
		rdKnown = 1'b1;
		if (rdWord == CTRL_ADDR) begin
			rdMux = ctrl_r;
		end else if (rdWord == STATUS_ADDR) begin
			rdMux = statusW;
		end else if (rdWord == PHASE_ADDR) begin
			rdMux = {refHalf_r, phaseOffset_r};
		end else if (rdWord == CAPTURE_ADDR) begin
			rdMux = {loadCount_r, 6'h00, heldCt_r, heldData_r};
		end else begin
			rdMux = 32'h0000_0000;
			rdKnown = 1'b0;
		end
	end

	// read channel: one read at a time, answered the cycle after the address is taken
	logic arready_r;
	logic rvalid_r;
	logic [31:0] rdata_r;
	logic [1:0] rresp_r;
	wire logic arTake = arvalid & arready_r;
	wire logic rvalid_nxt = arTake | (rvalid_r & ~rready);
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			arready_r <= 1'b0;
			rvalid_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
			rresp_r <= RESP_OKAY;
		end else begin
			rvalid_r <= rvalid_nxt;
			arready_r <= ~rvalid_nxt;
			if (arTake) begin
				rdata_r <= rdMux;
				rresp_r <= rdKnown ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// outputs, all straight from flops
	assign awready = awready_r;
	assign wready = wready_r;
	assign bvalid = bvalid_r;
	assign bresp = bresp_r;
	assign arready = arready_r;
	assign rvalid = rvalid_r;
	assign rdata = rdata_r;
	assign rresp = rresp_r;
	assign txClockOutput = txClock_r;
	assign txClockOutputN = txClockN_r;
	assign rxClockOutput = rxClock_r;
	assign rxClockCopyOutput = rxClockCopy_r;
	assign txHeldData = heldData_r;
	assign txHeldCharType = heldCt_r;
	assign txHeldStrobe = heldStrobe_r;

	// protection bits carry no meaning here
	wire logic unusedProt = ^{awprot, arprot, hostLevel};

endmodule

`default_nettype wire

//--- verilog/tcsrc_pkg.sv
// tcsrc_pkg: constants, levels, modes and field layouts for the transmit clock select and rate control block
`default_nettype none
package tcsrc_pkg;

	// register byte addresses
	localparam logic [31:0] CTRL_ADDR = 32'h0000_0000;
	localparam logic [31:0] STATUS_ADDR = 32'h0000_0004;
	localparam logic [31:0] PHASE_ADDR = 32'h0000_0008;
	localparam logic [31:0] CAPTURE_ADDR = 32'h0000_000c;
	localparam logic [31:0] ADDR_WORD_MASK = 32'h0000_00fc;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
	localparam logic [31:0] CTRL_MASK = 32'h0000_01ff;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// control register field positions
	localparam int CTRL_TXSEL_LSB = 0;
	localparam int CTRL_RATE_BIT = 2;
	localparam int CTRL_RXSEL_BIT = 3;
	localparam int CTRL_PHRST_BIT = 4;
	localparam int CTRL_MODE0_LSB = 5;
	localparam int CTRL_MODE1_LSB = 7;

	// multipliers of the transmit bit-rate clock over the reference clock
	localparam logic [4:0] PLL_MULT_FULL = 5'h0a;
	localparam logic [4:0] PLL_MULT_HALF = 5'h14;

	// three-level encoding: 00 low, 01 mid, 1x high
	localparam logic [1:0] LEVEL_MID_CODE = 2'h1;
	localparam int SYNC_WIDTH = 12;
	localparam int DATA_WIDTH = 8;
	localparam int CT_WIDTH = 2;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] MATCH_SLACK = 16'h0001;
	localparam logic [3:0] MODES_PER_LEVEL = 4'h3;

	typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} tcsrc_level_t;

	typedef enum logic [3:0] {
		MODE_0, MODE_1, MODE_2, MODE_3, MODE_4, MODE_5, MODE_6, MODE_7, MODE_8
	} tcsrc_mode_t;

	// static controls as software sets them
	typedef struct packed {
		logic [1:0] txMode1;
		logic [1:0] txMode0;
		logic txPhaseReset;
		logic rxSelect;
		logic rateSelect;
		logic [1:0] txInputSelect;
	} tcsrc_ctrl_t;

	// block state as software reads it
	typedef struct packed {
		logic [17:0] zero;
		logic hostFreqMismatch;
		logic phaseHeld;
		logic hostClockInUse;
		logic rxHalfRate;
		logic [4:0] pllMultiplier;
		logic invalidCombo;
		logic [3:0] modeIndex;
	} tcsrc_status_t;

endpackage

`default_nettype wire

//--- bench/tcsrc_props.sv
// tcsrc_props: bus and clock-output assertions for the transmit clock select block
`timescale 1ns/1ps
`default_nettype none
module tcsrc_props (
	// clock and reset
	input wire logic sys_clk,
	input wire logic reset,
	// register bus
	input wire logic awvalid,
	input wire logic awready,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	input wire logic [1:0] bresp,
	input wire logic arvalid,
	input wire logic arready,
	input wire logic rvalid,
	input wire logic rready,
	input wire logic [31:0] rdata,
	// clock outputs and input register
	input wire logic txClockOutput,
	input wire logic txClockOutputN,
	input wire logic rxClockOutput,
	input wire logic rxClockCopyOutput,
	input wire logic [7:0] txHeldData,
	input wire logic [1:0] txHeldCharType,
	input wire logic txHeldStrobe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	// output clock pair and receive copies
	chk_tx_complement: assert property (txClockOutputN == !txClockOutput)
		else $error("tx clock output pair not complementary");
	chk_rx_copy_same: assert property (rxClockOutput == rxClockCopyOutput)
		else $error("receive clock copy differs");
	// a load is one pulse and the register holds between loads
	chk_strobe_single: assert property (txHeldStrobe |=> !txHeldStrobe)
		else $error("load strobe longer than one cycle");
	chk_held_stable: assert property (!txHeldStrobe |-> $stable({txHeldData, txHeldCharType}))
		else $error("input register changed without a load");
	// bus answers and their holding
	chk_read_latency: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	chk_write_latency: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	chk_aw_single: assert property (awvalid && awready |=> !awready)
		else $error("write address taken twice");
	chk_bvalid_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
		else $error("write response dropped");
	chk_rdata_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
		else $error("read data dropped");
endmodule
`default_nettype wire

//--- bench/tcsrc_host_model.sv
// tcsrc_host_model: host logic that clocks words into the transmit input register
`timescale 1ns/1ps
`default_nettype none
module tcsrc_host_model (
	// clock, reset and run control
	input wire logic sys_clk,
	input wire logic reset,
	input wire logic run,
	// parallel transmit pins
	output logic hostClk,
	output logic [7:0] hostData,
	output logic [1:0] hostCt,
	// word sent at the latest host rising edge
	output logic [9:0] lastWord
);
	logic [2:0] cnt_r;
	logic clk_r;
	logic [9:0] word_r;
	assign hostClk = clk_r;
	assign {hostCt, hostData} = word_r;
	// eight-cycle half period matches the output clock at rate low; pausing run shifts phase
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cnt_r <= 3'h0;
			clk_r <= 1'b0;
			word_r <= 10'h15a;
			lastWord <= 10'h000;
		end else if (run) begin
			cnt_r <= cnt_r + 3'h1;
			if (cnt_r == 3'h7) clk_r <= ~clk_r;
			// data moves at the falling edge so it is steady around the rising one
			if (cnt_r == 3'h7 && !clk_r) lastWord <= word_r;
			if (cnt_r == 3'h7 && clk_r) word_r <= word_r + 10'h0a7;
		end
	end
endmodule
`default_nettype wire

//--- bench/tb.sv
// tb: register-bus and clock-pin regression of the transmit clock select block
`timescale 1ns/1ps
`default_nettype none
module tb;
	import tcsrc_pkg::*;
	logic sys_clk = 1'b0, reset = 1'b1, referenceClockIn = 1'b0, hostRun = 1'b0, chkData = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, d0, d1;
	logic awready, wready, bvalid, arready, rvalid, txClockOutput, txClockOutputN;
	logic rxClockOutput, rxClockCopyOutput, txHostInputClock, txHeldStrobe;
	logic [1:0] bresp, rresp, txCharacterType, txHeldCharType, rsp;
	logic [7:0] txDataIn, txHeldData;
	logic [9:0] lastWord;
	logic [2:0] refCnt = 3'h0;
	int badCount = 0, nChecks = 0, cyc = 0, rt, tt, xt, st;
	tcsrc_top u_tcsrc_top (.sys_clk(sys_clk), .reset(reset), .referenceClockIn(referenceClockIn),
		.txHostInputClock(txHostInputClock), .txDataIn(txDataIn), .txCharacterType(txCharacterType),
		.awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
		.wready(wready), .wdata(wdata), .wstrb(4'hf), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp), .txClockOutput(txClockOutput),
		.txClockOutputN(txClockOutputN), .rxClockOutput(rxClockOutput), .rxClockCopyOutput(rxClockCopyOutput),
		.txHeldData(txHeldData), .txHeldCharType(txHeldCharType), .txHeldStrobe(txHeldStrobe));
	tcsrc_host_model u_tcsrc_host_model (.sys_clk(sys_clk), .reset(reset), .run(hostRun),
		.hostClk(txHostInputClock), .hostData(txDataIn), .hostCt(txCharacterType), .lastWord(lastWord));
	initial forever #20 sys_clk = ~sys_clk;
	// reference pin toggles every eight cycles, long enough for the doubled output to fit
	always @(posedge sys_clk) begin
		refCnt <= refCnt + 3'h1;
		if (refCnt == 3'h7) referenceClockIn <= ~referenceClockIn;
		cyc++;
		if (cyc == 20000) begin
			badCount++;
			end_of_test;
		end
	end
	// every load while chkData is set must hold the word the host sent at its last rising edge
	always @(posedge sys_clk) begin
		if (chkData && txHeldStrobe === 1'b1) begin
			check({22'h0, txHeldCharType, txHeldData}, {22'h0, lastWord});
		end
	end
	task automatic fail(input logic [31:0] got, input logic [31:0] exp);
		badCount++;
		$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		nChecks++;
		if (got !== exp) fail(got, exp);
	endtask
	// clock counts may differ by a couple of edges at the window boundaries
	task automatic near(input int got, input int exp);
		nChecks++;
		if (got < exp - 2 || got > exp + 2) fail(got, exp);
	endtask
	task automatic axi_write(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge sys_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask
	task automatic axi_read(input logic [31:0] a);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (arready) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		d0 = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic rdchk(input logic [31:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] er);
		axi_read(a);
		check(d0 & m, exp);
		check({30'h0, rsp}, {30'h0, er});
	endtask
	// counts pin changes over 320 cycles, sampled after the edge settles
	task automatic measure;
		logic pr, pt, px;
		rt = 0;
		tt = 0;
		xt = 0;
		st = 0;
		pr = referenceClockIn;
		pt = txClockOutput;
		px = rxClockOutput;
		repeat (320) begin
			@(posedge sys_clk);
			#1;
			rt += (referenceClockIn !== pr);
			tt += (txClockOutput !== pt);
			xt += (rxClockOutput !== px);
			st += (txHeldStrobe === 1'b1);
			pr = referenceClockIn;
			pt = txClockOutput;
			px = rxClockOutput;
		end
	endtask
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", nChecks, badCount);
		if (badCount == 0 && nChecks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge sys_clk);
		reset <= 1'b0;
		// reset values, unmapped and read-only places, unused control bits
		rdchk(CTRL_ADDR, CTRL_RESET, 32'hffffffff, RESP_OKAY);
		rdchk(STATUS_ADDR, 32'h140, 32'hffffffff, RESP_OKAY);
		rdchk(32'h10, 32'h0, 32'hffffffff, RESP_SLVERR);
		axi_write(32'h10, 32'h1, RESP_SLVERR);
		axi_write(STATUS_ADDR, 32'hffffffff, RESP_OKAY);
		rdchk(STATUS_ADDR, 32'h140, 32'hffffffff, RESP_OKAY);
		axi_write(CTRL_ADDR, 32'hfffffffb, RESP_OKAY);
		rdchk(CTRL_ADDR, 32'h1fb, 32'hffffffff, RESP_OKAY);
		$display("test regs done");
		// rate select: multiplier, output clock rates, loads from the reference
		for (int r = 0; r < 2; r++) begin
			axi_write(CTRL_ADDR, 32'(r * 4), RESP_OKAY);
			d1 = {21'h0, 1'(r), (r ? PLL_MULT_HALF : PLL_MULT_FULL), 5'h0};
			rdchk(STATUS_ADDR, d1, 32'h7e0, RESP_OKAY);
			repeat (32) @(posedge sys_clk);
			measure;
			near(tt, rt * (r + 1));
			near(xt, rt);
			near(st, rt / 2);
		end
		$display("test rate done");
		// host clock as load clock: a stopped host gives no loads
		axi_write(CTRL_ADDR, 32'h1, RESP_OKAY);
		// a host clock that never toggled cannot match the output clock, so mismatch shows
		rdchk(STATUS_ADDR, 32'h2800, 32'h2800, RESP_OKAY);
		measure;
		near(st, 0);
		// last reference load still holds the idle host word
		rdchk(CAPTURE_ADDR, 32'h15a, 32'h3ff, RESP_OKAY);
		hostRun <= 1'b1;
		for (int s = 1; s < 4; s++) begin
			axi_write(CTRL_ADDR, 32'(s), RESP_OKAY);
			chkData <= 1'b1;
			measure;
			chkData <= 1'b0;
			near(st, rt / 2);
			rdchk(STATUS_ADDR, 32'h800, 32'h2800, RESP_OKAY);
		end
		$display("test host clock done");
		// phase tracking frozen while the phase reset is high
		axi_write(CTRL_ADDR, 32'h11, RESP_OKAY);
		rdchk(STATUS_ADDR, 32'h1000, 32'h1000, RESP_OKAY);
		repeat (40) @(posedge sys_clk);
		axi_read(PHASE_ADDR);
		d1 = d0;
		check({16'h0, d1[31:16]}, 32'h8);
		hostRun <= 1'b0;
		repeat (5) @(posedge sys_clk);
		hostRun <= 1'b1;
		repeat (64) @(posedge sys_clk);
		axi_read(PHASE_ADDR);
		check(d0 & 32'hffff, d1 & 32'hffff);
		axi_write(CTRL_ADDR, 32'h1, RESP_OKAY);
		repeat (64) @(posedge sys_clk);
		axi_read(PHASE_ADDR);
		nChecks++;
		if (d0[15:0] === d1[15:0]) fail(d0, d1);
		$display("test phase done");
		// park the host clock so a late host edge cannot chase the switch back to the reference
		hostRun <= 1'b0;
		repeat (8) @(posedge sys_clk);
		// nine modes from the two three-level inputs
		for (int m = 0; m < 9; m++) begin
			axi_write(CTRL_ADDR, {23'h0, 2'(m / 3), 2'(m % 3), 5'h0}, RESP_OKAY);
			rdchk(STATUS_ADDR, 32'(m), 32'h1f, RESP_OKAY);
		end
		$display("test modes done");
		end_of_test;
	end
endmodule
bind tcsrc_top tcsrc_props u_tcsrc_props (.sys_clk(sys_clk), .reset(reset), .awvalid(awvalid),
	.awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
	.arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata),
	.txClockOutput(txClockOutput), .txClockOutputN(txClockOutputN), .rxClockOutput(rxClockOutput),
	.rxClockCopyOutput(rxClockCopyOutput), .txHeldData(txHeldData), .txHeldCharType(txHeldCharType),
	.txHeldStrobe(txHeldStrobe));
`default_nettype wire
